// File: hdl/plc_counter_timer_units.sv
// Notes on behaviour
// [R1] Rising count-up input adds one to the stored count.
// [R2] Rising count-down input subtracts one from the stored count.
// [R3] Rising set input loads the count from the preset value.
// [R4] The counter preset is BCD, zero to 999; software guarantees it.
// [R5] Counter reset input at one forces count and flag to zero.
// [R6] Count is shown both as plain binary and as BCD.
// [R7] Counter flag is one when count above zero, else zero.
// [R8] 256 counters, index from zero, each holding 0 to 999.
// [R9] Timers start on rising start input; off-delay starts on falling.
// [R10] Five start kinds: one-shot, stretched, on-delay, held on-delay, off-delay.
// [R11] Timer preset is a count 0 to 999 plus a two-bit base.
// [R12] Base code 0,1,2,3 gives 10 ms, 100 ms, 1 s, 10 s ticks.
// [R13] Timer reset input changing to one clears value and flag.
// [R14] Timer remaining value is shown as binary and as BCD.
// [R15] Timer flag is one while running, zero when stopped or elapsed.
// [R16] 256 timers, numbered from zero.
// [R17] Counter saturates at zero and at 999, never wraps.
// [R18] Timer decrements once per base tick and stops at zero.
//
// The APB register port and the register addresses were left to the implementer.
module plc_counter_timer_units #(
    parameter int BASE_FINE_CYCLES = plc_units_pkg::BASE_FINE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ==========================================
    // Code conversion
    function automatic logic [11:0] to_bcd(input logic [9:0] bin);
        logic [21:0] work;
        work = {12'h000, bin};
        for (int i = 0; i < 10; i++) begin
            if (work[13:10] > 4'h4) begin
                work[13:10] = work[13:10] + 4'h3;
            end
            if (work[17:14] > 4'h4) begin
                work[17:14] = work[17:14] + 4'h3;
            end
            if (work[21:18] > 4'h4) begin
                work[21:18] = work[21:18] + 4'h3;
            end
            work = {work[20:0], 1'b0};
        end
        return work[21:10];
    endfunction

    // Digits above nine are out of contract; the result is clamped to 999
    function automatic logic [9:0] from_bcd(input logic [11:0] bcd);
        logic [13:0] sum;
        sum = 14'(bcd[11:8]) * 14'h064 + 14'(bcd[7:4]) * 14'h00A + 14'(bcd[3:0]);
        if (sum > 14'(plc_units_pkg::COUNT_MAX)) begin
            sum = 14'(plc_units_pkg::COUNT_MAX);
        end
        return sum[9:0];
    endfunction

    // ==========================================
    // Storage
    logic [9:0] count_value [plc_units_pkg::UNIT_COUNT]; // R8
    logic [2:0] count_prev [plc_units_pkg::UNIT_COUNT];
    logic [9:0] timer_value [plc_units_pkg::UNIT_COUNT]; // R16
    logic [1:0] timer_base [plc_units_pkg::UNIT_COUNT];
    logic [2:0] timer_kind [plc_units_pkg::UNIT_COUNT];
    logic timer_running [plc_units_pkg::UNIT_COUNT];
    logic [1:0] timer_prev [plc_units_pkg::UNIT_COUNT];
    logic [7:0] cnt_sel;
    logic [7:0] tmr_sel;

    // ==========================================
    // Bus decode
    logic setup_phase;
    logic bus_write;
    logic addr_known;
    logic busy;
    plc_units_pkg::cnt_cmd_type cnt_cmd;
    plc_units_pkg::tmr_cmd_type tmr_cmd;

    assign setup_phase = psel && !penable;
    assign bus_write = psel && penable && pready && pwrite && !pslverr;
    assign addr_known = paddr == 32'(plc_units_pkg::CNT_CMD_ADDR)
        || paddr == 32'(plc_units_pkg::CNT_STAT_ADDR)
        || paddr == 32'(plc_units_pkg::TMR_CMD_ADDR)
        || paddr == 32'(plc_units_pkg::TMR_STAT_ADDR);
    assign cnt_cmd = plc_units_pkg::cnt_cmd_type'(pwdata);
    assign tmr_cmd = plc_units_pkg::tmr_cmd_type'(pwdata);

    // ==========================================
    // Time base dividers
    logic [31:0] fine_div;
    logic [3:0] dec_div [3];
    logic [3:0] tick;
    logic [3:0] tick_pending;
    logic [3:0] tick_taken;

    // One process owns every tick bit
    // Each slower base is a tenth of the one below it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fine_div <= 32'h0000_0000;
            tick <= 4'h0;
            for (int i = 0; i < 3; i++) begin
                dec_div[i] <= 4'h0;
            end
        end else begin
            tick <= 4'h0;
            if (fine_div == 32'(BASE_FINE_CYCLES - 1)) begin
                fine_div <= 32'h0000_0000;
                tick[0] <= 1'b1; // R12
            end else begin
                fine_div <= fine_div + 32'h0000_0001;
            end
            for (int i = 0; i < 3; i++) begin
                if (tick[i]) begin
                    if (dec_div[i] == plc_units_pkg::DECADE_LAST) begin
                        dec_div[i] <= 4'h0;
                        tick[i + 1] <= 1'b1; // R12
                    end else begin
                        dec_div[i] <= dec_div[i] + 4'h1;
                    end
                end
            end
        end
    end

    // ==========================================
    // Tick sweep over all timers
    plc_units_pkg::sweep_state_type sweep_state;
    logic [7:0] sweep_idx;

    assign busy = sweep_state == plc_units_pkg::sweep_run;

    // A tick arriving while its bit is cleared stays pending
    // Ticks closer together than one sweep merge into a single step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_pending <= 4'h0;
        end else if (busy && sweep_idx == 8'hFF) begin
            tick_pending <= (tick_pending & ~tick_taken) | tick;
        end else begin
            tick_pending <= tick_pending | tick;
        end
    end

    // Sweep waits for the bus to be quiet so it never meets a command
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sweep_state <= plc_units_pkg::sweep_idle;
            sweep_idx <= 8'h00;
            tick_taken <= 4'h0;
        end else begin
            unique case (sweep_state)
                plc_units_pkg::sweep_idle: begin
                    if (tick_pending != 4'h0 && !psel) begin
                        sweep_state <= plc_units_pkg::sweep_run;
                        sweep_idx <= 8'h00;
                        tick_taken <= tick_pending;
                    end
                end
                plc_units_pkg::sweep_run: begin
                    sweep_idx <= sweep_idx + 8'h01;
                    if (sweep_idx == 8'hFF) begin
                        sweep_state <= plc_units_pkg::sweep_idle;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Counters
    // Stored input bits make each write one scan of that counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_sel <= 8'h00;
            for (int i = 0; i < plc_units_pkg::UNIT_COUNT; i++) begin
                count_value[i] <= plc_units_pkg::VALUE_ZERO;
                count_prev[i] <= 3'b000;
            end
        end else if (bus_write && paddr == 32'(plc_units_pkg::CNT_CMD_ADDR)) begin
            cnt_sel <= cnt_cmd.index;
            count_prev[cnt_cmd.index] <= {cnt_cmd.set_in, cnt_cmd.down_in, cnt_cmd.up_in};
            if (cnt_cmd.reset_in) begin
                count_value[cnt_cmd.index] <= plc_units_pkg::VALUE_ZERO; // R5
            end else if (cnt_cmd.set_in && !count_prev[cnt_cmd.index][2]) begin
                count_value[cnt_cmd.index] <= from_bcd(cnt_cmd.preset_bcd); // R3 R4
            end else begin
                count_value[cnt_cmd.index] <= next_count(count_value[cnt_cmd.index],
                    cnt_cmd.up_in && !count_prev[cnt_cmd.index][0],
                    cnt_cmd.down_in && !count_prev[cnt_cmd.index][1]);
            end
        end
    end

    // Both edges in one scan cancel out
    function automatic logic [9:0] next_count(input logic [9:0] cur, input logic up,
        input logic down);
        logic [9:0] res;
        res = cur;
        if (up && !down && cur != plc_units_pkg::COUNT_MAX) begin
            res = cur + 10'h001; // R1 R17
        end else if (down && !up && cur != plc_units_pkg::VALUE_ZERO) begin
            res = cur - 10'h001; // R2 R17
        end
        return res;
    endfunction

    // ==========================================
    // Timers
    logic t_rise;
    logic t_fall;
    logic r_rise;
    logic [9:0] t_preset;
    logic [7:0] ti;

    assign ti = tmr_cmd.index;
    assign t_rise = tmr_cmd.start_in && !timer_prev[ti][0];
    assign t_fall = !tmr_cmd.start_in && timer_prev[ti][0];
    assign r_rise = tmr_cmd.reset_in && !timer_prev[ti][1];
    assign t_preset = from_bcd(tmr_cmd.preset_bcd);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmr_sel <= 8'h00;
            for (int i = 0; i < plc_units_pkg::UNIT_COUNT; i++) begin
                timer_value[i] <= plc_units_pkg::VALUE_ZERO;
                timer_base[i] <= 2'b00;
                timer_kind[i] <= 3'b000;
                timer_running[i] <= 1'b0;
                timer_prev[i] <= 2'b00;
            end
        end else if (bus_write && paddr == 32'(plc_units_pkg::TMR_CMD_ADDR)) begin
            tmr_sel <= ti;
            timer_prev[ti] <= {tmr_cmd.reset_in, tmr_cmd.start_in};
            // Reset edge wins over any start action
            if (r_rise) begin
                timer_value[ti] <= plc_units_pkg::VALUE_ZERO; // R13
                timer_running[ti] <= 1'b0; // R13
            end else begin
                unique case (plc_units_pkg::timer_kind_type'(tmr_cmd.kind)) // R10
                    plc_units_pkg::timer_one_shot_kind,
                    plc_units_pkg::timer_on_delay_kind: begin
                        if (t_rise) begin // R9
                            timer_value[ti] <= t_preset; // R11
                            timer_base[ti] <= tmr_cmd.base;
                            timer_running[ti] <= t_preset != plc_units_pkg::VALUE_ZERO;
                        end else if (t_fall) begin
                            timer_running[ti] <= 1'b0;
                        end
                    end
                    plc_units_pkg::timer_stretched_kind: begin
                        if (t_rise) begin // R9
                            timer_value[ti] <= t_preset;
                            timer_base[ti] <= tmr_cmd.base;
                            timer_running[ti] <= t_preset != plc_units_pkg::VALUE_ZERO;
                        end
                    end
                    plc_units_pkg::timer_held_on_delay_kind: begin
                        // Held kind ignores a new start while already running
                        if (t_rise && !timer_running[ti]) begin // R9
                            timer_value[ti] <= t_preset;
                            timer_base[ti] <= tmr_cmd.base;
                            timer_running[ti] <= t_preset != plc_units_pkg::VALUE_ZERO;
                        end
                    end
                    plc_units_pkg::timer_off_delay_kind: begin
                        if (t_fall) begin // R9
                            timer_value[ti] <= t_preset;
                            timer_base[ti] <= tmr_cmd.base;
                            timer_running[ti] <= t_preset != plc_units_pkg::VALUE_ZERO;
                        end else if (t_rise) begin
                            timer_running[ti] <= 1'b0;
                        end
                    end
                    default: begin
                        timer_running[ti] <= timer_running[ti];
                    end
                endcase
            end
            timer_kind[ti] <= tmr_cmd.kind;
        end else if (busy && timer_running[sweep_idx]
            && tick_taken[timer_base[sweep_idx]]) begin
            timer_value[sweep_idx] <= timer_value[sweep_idx] - 10'h001; // R18
            if (timer_value[sweep_idx] == 10'h001) begin
                timer_running[sweep_idx] <= 1'b0; // R18 R15
            end
        end
    end

    // ==========================================
    // Read data and handshake
    plc_units_pkg::unit_stat_type cnt_stat;
    plc_units_pkg::unit_stat_type tmr_stat;
    logic [31:0] next_prdata;

    always_comb begin
        cnt_stat = '0;
        cnt_stat.value_plain = count_value[cnt_sel]; // R6
        cnt_stat.value_bcd = to_bcd(count_value[cnt_sel]); // R6
        cnt_stat.flag = count_value[cnt_sel] != plc_units_pkg::VALUE_ZERO; // R7
        tmr_stat = '0;
        tmr_stat.value_plain = timer_value[tmr_sel]; // R14
        tmr_stat.value_bcd = to_bcd(timer_value[tmr_sel]); // R14
        tmr_stat.flag = timer_running[tmr_sel]; // R15
        next_prdata = 32'h0000_0000;
        if (paddr == 32'(plc_units_pkg::CNT_STAT_ADDR)) begin
            next_prdata = 32'(cnt_stat);
        end else if (paddr == 32'(plc_units_pkg::TMR_STAT_ADDR)) begin
            next_prdata = 32'(tmr_stat);
        end else if (paddr == 32'(plc_units_pkg::CNT_CMD_ADDR)) begin
            next_prdata = {24'h000000, cnt_sel};
        end else if (paddr == 32'(plc_units_pkg::TMR_CMD_ADDR)) begin
            next_prdata = {24'h000000, tmr_sel};
        end
    end

    // Answer is held back while a sweep runs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= plc_units_pkg::CMD_RESET;
        end else if (psel && !pready && !busy && (setup_phase || penable)) begin
            pready <= 1'b1;
            pslverr <= !addr_known;
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule

// File: common/plc_units_pkg.sv
package plc_units_pkg;

    // ==========================================
    // Register map (byte addresses on APB)
    localparam logic [7:0] CNT_CMD_ADDR = 8'h00;
    localparam logic [7:0] CNT_STAT_ADDR = 8'h04;
    localparam logic [7:0] TMR_CMD_ADDR = 8'h08;
    localparam logic [7:0] TMR_STAT_ADDR = 8'h0C;

    // ==========================================
    // Sizes and limits
    localparam int UNIT_COUNT = 256;
    localparam logic [9:0] COUNT_MAX = 10'h3E7;
    localparam logic [9:0] VALUE_ZERO = 10'h000;
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;

    // ==========================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int BASE_FINE_MS = 10;
    localparam int BASE_FINE_CYCLES = BASE_FINE_MS * 1000 * CLK_MHZ;
    localparam logic [3:0] DECADE_LAST = 4'h9;

    // ==========================================
    // Field layouts, MSB first
    typedef struct packed {
        logic [7:0] spare;
        logic [11:0] preset_bcd;
        logic reset_in;
        logic set_in;
        logic down_in;
        logic up_in;
        logic [7:0] index;
    } cnt_cmd_type;

    typedef struct packed {
        logic [3:0] spare_hi;
        logic [11:0] preset_bcd;
        logic spare_lo;
        logic [1:0] base;
        logic reset_in;
        logic start_in;
        logic [2:0] kind;
        logic [7:0] index;
    } tmr_cmd_type;

    typedef struct packed {
        logic flag;
        logic [6:0] spare_hi;
        logic [11:0] value_bcd;
        logic [1:0] spare_lo;
        logic [9:0] value_plain;
    } unit_stat_type;

    typedef enum logic [2:0] {
        timer_one_shot_kind = 3'b000,
        timer_stretched_kind = 3'b001,
        timer_on_delay_kind = 3'b010,
        timer_held_on_delay_kind = 3'b011,
        timer_off_delay_kind = 3'b100
    } timer_kind_type;

    typedef enum logic [0:0] {
        sweep_idle = 1'b0,
        sweep_run = 1'b1
    } sweep_state_type;

endpackage

// File: tb/plc_units_monitor.sv
module plc_units_monitor #(
    parameter int BASE_FINE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic ok_addr;
    logic stat_rd;
    logic cnt_rd;
    logic [9:0] v;
    assign ok_addr = paddr[31:4] == 28'h0 && paddr[1:0] == 2'h0;
    assign stat_rd = pready && !pwrite && ok_addr && paddr[2];
    assign cnt_rd = stat_rd && !paddr[3];
    assign v = prdata[9:0];

    function automatic logic [11:0] dec(input logic [9:0] x);
        logic [9:0] h;
        logic [9:0] t;
        h = x / 10'h064;
        t = x / 10'h00A % 10'h00A;
        return {h[3:0], t[3:0], 4'(x % 10'h00A)};
    endfunction

    // ==========================================
    // Bus answers and status words
    property p_ready_access; pready |-> psel && penable; endproperty
    a_ready_access: assert property (p_ready_access) else $error("ready outside access");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    // Sweep can stall the answer for about 257 cycles
    property p_ready_bound; psel && !penable |-> ##[1:300] pready; endproperty
    a_ready_bound: assert property (p_ready_bound) else $error("no answer");
    property p_err_map; pready |-> pslverr == !ok_addr; endproperty
    a_err_map: assert property (p_err_map) else $error("error flag wrong");
    property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    property p_rdata_hold; !pready |-> $stable(prdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_cnt_flag; cnt_rd |-> prdata[31] == (v != 10'h000); endproperty
    a_cnt_flag: assert property (p_cnt_flag) else $error("count flag wrong");
    property p_cnt_range; cnt_rd |-> v <= plc_units_pkg::COUNT_MAX; endproperty
    a_cnt_range: assert property (p_cnt_range) else $error("count out of range");
    property p_bcd; stat_rd |-> prdata[23:12] == dec(v); endproperty
    a_bcd: assert property (p_bcd) else $error("decimal value wrong");
    property p_tmr_run; stat_rd && paddr[3] && prdata[31] |-> v != 10'h000; endproperty
    a_tmr_run: assert property (p_tmr_run) else $error("running at zero");
    c_cnt_max: cover property (cnt_rd && v == plc_units_pkg::COUNT_MAX);
    c_tmr_run: cover property (stat_rd && paddr[3] && prdata[31]);
    c_err: cover property (pready && pslverr);
endmodule

bind plc_counter_timer_units plc_units_monitor #(.BASE_FINE_CYCLES(BASE_FINE_CYCLES)) u_mon (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
);

// File: tb/plc_logic_model.sv
module plc_logic_model (
    input wire logic clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int idle = 1;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end

    function automatic logic [11:0] to_bcd(input int n);
        return {4'(n / 100), 4'(n / 10 % 10), 4'(n % 10)};
    endfunction

    // ==========================================
    // One scan of logic results per transfer
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not look like the old request
        paddr <= ~a;
        pwdata <= ~d;
        repeat (idle) @(posedge clk);
    endtask

    task automatic cnt_scan(input logic [7:0] idx, input logic [3:0] ctl, input int preset);
        plc_units_pkg::cnt_cmd_type c;
        logic [31:0] d;
        logic e;
        c = '0;
        c.index = idx;
        {c.reset_in, c.set_in, c.down_in, c.up_in} = ctl;
        c.preset_bcd = to_bcd(preset);
        xfer(1'b1, {24'h0, plc_units_pkg::CNT_CMD_ADDR}, c, d, e);
    endtask

    task automatic tmr_scan(input logic [7:0] idx, input logic [2:0] kind, input logic go,
        input logic clr, input logic [1:0] base, input int preset);
        plc_units_pkg::tmr_cmd_type c;
        logic [31:0] d;
        logic e;
        c = '0;
        c.index = idx;
        c.kind = kind;
        c.start_in = go;
        c.reset_in = clr;
        c.base = base;
        c.preset_bcd = to_bcd(preset);
        xfer(1'b1, {24'h0, plc_units_pkg::TMR_CMD_ADDR}, c, d, e);
    endtask
endmodule

// File: tb/plc_counter_timer_units_tb_top.sv
module plc_counter_timer_units_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 20;
    // Control bits are reset, set, down, up
    localparam logic [3:0] CTL [14] = '{4'h4, 4'h0, 4'h1, 4'h1, 4'h0, 4'h1, 4'h2, 4'h0, 4'h9,
        4'h0, 4'h2, 4'h4, 4'h1, 4'h0};
    localparam int PRE [14] = '{5, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 999, 0, 0};
    localparam int EXP [14] = '{5, 5, 6, 6, 6, 7, 6, 6, 0, 0, 0, 999, 999, 999};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    int n_fail = 0;
    int tests_run = 0;
    int p;

    always #5 clk = ~clk;

    plc_counter_timer_units #(.BASE_FINE_CYCLES(TICK)) u_dut (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    plc_logic_model u_logic (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // ==========================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    function automatic logic [31:0] word(input int n, input logic f);
        return {f, 7'h00, u_logic.to_bcd(n), 2'b00, 10'(n)};
    endfunction

    task automatic rd_at(input logic [7:0] a);
        u_logic.xfer(1'b0, {24'h0, a}, 32'h0, rd, err);
    endtask

    task automatic tmr_flag(input logic f);
        rd_at(plc_units_pkg::TMR_STAT_ADDR);
        check({31'h0, rd[31]}, {31'h0, f});
    endtask

    // ==========================================
    // Sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int u = 0; u < 2; u++) begin
            for (int s = 0; s < 14; s++) begin
                u_logic.cnt_scan(8'(u * 255), CTL[s], PRE[s]);
                rd_at(plc_units_pkg::CNT_STAT_ADDR);
                check(rd, word(EXP[s], EXP[s] != 0));
            end
        end
        u_logic.xfer(1'b0, 32'h10, 32'h0, rd, err);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        u_logic.xfer(1'b1, 32'h40, 32'hFFFF_FFFF, rd, err);
        check({31'h0, err}, 32'h1);
        u_logic.xfer(1'b1, {24'h0, plc_units_pkg::CNT_STAT_ADDR}, 32'h0, rd, err);
        check({31'h0, err}, 32'h0);
        rd_at(plc_units_pkg::CNT_STAT_ADDR);
        check(rd, word(999, 1'b1));
        u_logic.idle = 3;
        for (int k = 0; k < 5; k++) begin
            u_logic.tmr_scan(8'(k), 3'(k), k == 4, 1'b0, 2'd0, 3);
            tmr_flag(1'b0);
            u_logic.tmr_scan(8'(k), 3'(k), k != 4, 1'b0, 2'd0, 3);
            tmr_flag(1'b1);
            repeat (3 * (TICK + 300)) @(posedge clk);
            rd_at(plc_units_pkg::TMR_STAT_ADDR);
            check(rd, word(0, 1'b0));
        end
        u_logic.tmr_scan(8'd255, 3'd2, 1'b1, 1'b0, 2'd3, 50);
        tmr_flag(1'b1);
        check({31'h0, rd[9:0] >= 10'd49 && rd[9:0] <= 10'd50}, 32'h1);
        u_logic.tmr_scan(8'd255, 3'd2, 1'b1, 1'b1, 2'd3, 50);
        rd_at(plc_units_pkg::TMR_STAT_ADDR);
        check(rd, word(0, 1'b0));
        for (int b = 0; b < 4; b++) begin
            p = TICK * (10 ** b);
            // Two base periods keep the slowest base inside the run budget
            u_logic.tmr_scan(8'(10 + b), 3'h1, 1'b1, 1'b0, 2'(b), 2);
            repeat (p * 9 / 10) @(posedge clk);
            tmr_flag(1'b1);
            repeat (p * 11 / 10 + 900) @(posedge clk);
            rd_at(plc_units_pkg::TMR_STAT_ADDR);
            check(rd, word(0, 1'b0));
        end
        print_verdict();
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule
